/* rtl/cbc_capability_unit.sv */
/*
  Capability unit of the core: widened register file with tags,
  pointer arithmetic with representability check, bounds inspection,
  tagged capability memory and program counter capability checks.
  Assumes one core clock, a synchronous reset and a pipeline that
  drives single-cycle requests.
*/
// How it works
// R01: Embedded format decodes with exponent zero.
// R02: Internal format takes exponent from mantissa bits.
// R03: Upper top bits rebuilt from base plus carry.
// R04: Boundary is upper base bits minus one.
// R05: Address may roam below base and above top.
// R06: Wrapping top gets its top bit inverted.
// R07: Top is one bit wider than address.
// R08: All-zero capability spans whole space, no permissions.
// R09: Root capability: all permissions, whole space bounds.
// R10: Representable when old and new bounds match.
// R11: Unrepresentable address change clears tag silently.
// R12: Malformed: negative or oversized exponent with base bits.
// R13: Malformed check ignores reserved bits.
// R14: Malformed capabilities never carry a tag.
// R15: One tag per aligned capability word.
// R16: Tag and data update together.
// R17: Addresses and representable region wrap around.
// R18: Thirty-two registers widened, each with tag.
// R19: Register zero reads all zero always.
// R20: Program counter capability resets to root, tagged.
// R21: Each instruction checks tag, seal, execute, bounds.
// R22: Mantissa width ten for 32-bit addresses.
// R23: Exponent five bits, maximum twenty-four.
// R24: Corrections are plus one, minus one or zero.
// R25: Bounds substitute mantissa at exponent position.
// R26: Decoder, checks and malformed flag are combinational; other flags are registered.
`timescale 1ns/1ps
`include "cbc_regs.svh"

module cbc_capability_unit (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // Register file read
  input  wire logic [`CBC_RIDX_W-1:0] rf_rd_addr_a,
  input  wire logic [`CBC_RIDX_W-1:0] rf_rd_addr_b,
  output logic      [`CBC_CW-1:0]     rf_rd_cap_a,
  output logic                        rf_rd_tag_a,
  output logic      [`CBC_AW-1:0]     rf_rd_int_a,
  output logic      [`CBC_CW-1:0]     rf_rd_cap_b,
  output logic                        rf_rd_tag_b,
  output logic      [`CBC_AW-1:0]     rf_rd_int_b,
  // Register file write
  input  wire logic                   rf_wr_en,
  input  wire logic                   rf_wr_int,
  input  wire logic [`CBC_RIDX_W-1:0] rf_wr_addr,
  input  wire logic [`CBC_CW-1:0]     rf_wr_cap,
  input  wire logic                   rf_wr_tag,
  // Pointer arithmetic
  input  wire logic                   ar_valid,
  input  wire cbc_pkg::cbc_op_type    ar_op,
  input  wire logic [`CBC_CW-1:0]     ar_cap,
  input  wire logic                   ar_tag,
  input  wire logic [`CBC_AW-1:0]     ar_operand,
  output logic                        ar_res_valid,
  output logic      [`CBC_CW-1:0]     ar_res_cap,
  output logic                        ar_res_tag,
  output logic                        ar_res_repr,
  // Bounds inspection
  input  wire logic [`CBC_CW-1:0]     in_cap,
  output logic      [`CBC_AW-1:0]     in_base,
  output logic      [`CBC_AW:0]       in_top,
  output logic                        in_malformed,
  // Null and root constants
  output logic      [`CBC_CW-1:0]     null_cap,
  output logic      [`CBC_CW-1:0]     root_cap,
  // Tagged memory
  input  wire logic                   mem_valid,
  input  wire logic                   mem_we,
  input  wire logic [`CBC_AW-1:0]     mem_addr,
  input  wire logic [`CBC_CW-1:0]     mem_wdata,
  input  wire logic                   mem_wtag,
  output logic                        mem_rvalid,
  output logic      [`CBC_CW-1:0]     mem_rdata,
  output logic                        mem_rtag,
  output logic                        mem_misaligned,
  // Program counter capability
  input  wire logic                   pcc_load,
  input  wire logic [`CBC_CW-1:0]     pcc_load_cap,
  input  wire logic                   pcc_load_tag,
  input  wire logic                   instr_valid,
  input  wire logic [2:0]             instr_len,
  input  wire logic [`CBC_AW-1:0]     pcc_next_addr,
  output logic      [`CBC_CW-1:0]     pcc_cap,
  output logic                        pcc_tag,
  output logic                        pcc_fault
);

  cbc_pkg::cbc_state_type state;
  cbc_pkg::cbc_state_type next_state;

  // Register 0 is never stored, so no storage cell for it exists
  logic [`CBC_CW-1:0]    rf_cap [1:`CBC_NREG-1];
  logic                  rf_tag [1:`CBC_NREG-1];
  logic [`CBC_CW-1:0]    mem_data [0:(1<<`CBC_TMEM_AW)-1];
  logic                  mem_tag  [0:(1<<`CBC_TMEM_AW)-1];

  cbc_pkg::cbc_cap_type  arc;
  cbc_pkg::cbc_cap_type  pcc_c;
  logic [`CBC_AW-1:0]    ar_new_addr;
  logic [`CBC_CW-1:0]    ar_new_cap;
  logic [`CBC_AW-1:0]    old_base;
  logic [`CBC_AW:0]      old_top;
  logic                  old_malformed;
  logic [`CBC_AW-1:0]    new_base;
  logic [`CBC_AW:0]      new_top;
  logic [`CBC_AW-1:0]    pcc_base;
  logic [`CBC_AW:0]      pcc_top;
  logic                  pcc_malformed;
  logic                  pcc_ok;
  logic [`CBC_AW:0]      pcc_end;
  logic                  rf_wr_ok;
  logic                  rf_wr_tag_eff;
  logic                  mem_word_ok;
  logic                  mem_wtag_eff;
  logic [`CBC_TMEM_AW-1:0] mem_idx;

  // Address of a capability, used for the integer view
  function automatic logic [`CBC_AW-1:0] cbc_addr_of(logic [`CBC_CW-1:0] v);
    return v[`CBC_AW-1:0];
  endfunction : cbc_addr_of

  // Register read with register 0 hardwired to null
  function automatic logic [`CBC_CW:0] cbc_rf_read(logic [`CBC_RIDX_W-1:0] idx,
                                                   logic [`CBC_CW-1:0] cap,
                                                   logic tag);
    if (idx == 5'h00)
      return '0;                                        // see R19
    else
      return {tag, cap};
  endfunction : cbc_rf_read

  // Inspection port: pure decode, same cycle
  cbc_bounds_decode u_dec_in (
    .cap       (in_cap),
    .addr      (cbc_addr_of(in_cap)),
    .base      (in_base),
    .top       (in_top),
    .malformed (in_malformed)
  );                                                    // see R26

  // Pointer arithmetic decodes twice: old and new address
  always_comb
  begin
    arc = cbc_pkg::cbc_cap_type'(ar_cap);
    if (ar_op == cbc_pkg::CBC_OP_INC)
      ar_new_addr = arc.addr + ar_operand;              // see R17
    else
      ar_new_addr = ar_operand;
    ar_new_cap = {ar_cap[`CBC_CW-1:`CBC_AW], ar_new_addr};
  end

  cbc_bounds_decode u_dec_old (
    .cap       (ar_cap),
    .addr      (arc.addr),
    .base      (old_base),
    .top       (old_top),
    .malformed (old_malformed)
  );

  cbc_bounds_decode u_dec_new (
    .cap       (ar_new_cap),
    .addr      (ar_new_addr),
    .base      (new_base),
    .top       (new_top),
    .malformed ()
  );

  // Program counter capability decode
  assign pcc_c = cbc_pkg::cbc_cap_type'(state.pcc_cap);

  cbc_bounds_decode u_dec_pcc (
    .cap       (state.pcc_cap),
    .addr      (pcc_c.addr),
    .base      (pcc_base),
    .top       (pcc_top),
    .malformed (pcc_malformed)
  );

  // Instruction end is one past its last byte, 33 bits so no wrap
  assign pcc_end = {1'b0, pcc_c.addr} + {30'h0, instr_len};

  assign pcc_ok = state.pcc_tag
                  && !pcc_malformed
                  && !pcc_c.sealed
                  && pcc_c.ap[`CBC_PERM_X]
                  && (pcc_c.addr >= pcc_base)
                  && (pcc_end <= pcc_top);              // see R21

  // Register write: integer writes zero metadata and tag
  always_comb
  begin
    rf_wr_ok      = rf_wr_en && (rf_wr_addr != 5'h00);  // see R19
    rf_wr_tag_eff = rf_wr_tag && !rf_wr_int
                    && !cbc_pkg::cbc_malformed(cbc_pkg::cbc_cap_type'(rf_wr_cap)); // see R14
  end

  always_ff @(posedge clk_sys)
  begin
    if (rf_wr_ok)
    begin
      if (rf_wr_int)
        rf_cap[rf_wr_addr] <= {32'h0000_0000, cbc_addr_of(rf_wr_cap)}; // see R18
      else
        rf_cap[rf_wr_addr] <= rf_wr_cap;
      rf_tag[rf_wr_addr] <= rf_wr_tag_eff;              // see R18
    end
  end

  // Memory: one tag per aligned 8-byte word; higher bits alias
  always_comb
  begin
    mem_idx      = mem_addr[`CBC_WORD_LSB +: `CBC_TMEM_AW];
    mem_word_ok  = mem_addr[`CBC_WORD_LSB-1:0] == 3'h0; // see R15
    mem_wtag_eff = mem_wtag
                   && !cbc_pkg::cbc_malformed(cbc_pkg::cbc_cap_type'(mem_wdata)); // see R14
  end

  // Data and tag share one edge, so no partial update is visible
  always_ff @(posedge clk_sys)
  begin
    if (mem_valid && mem_we && mem_word_ok)
    begin
      mem_data[mem_idx] <= mem_wdata;                   // see R16
      mem_tag[mem_idx]  <= mem_wtag_eff;                // see R16
    end
  end

  // Next state of all registered outputs
  always_comb
  begin
    next_state = state;

    // Register reads
    {next_state.rd_tag_a, next_state.rd_cap_a} =
      cbc_rf_read(rf_rd_addr_a,
                  (rf_rd_addr_a == 5'h00) ? '0 : rf_cap[rf_rd_addr_a],
                  (rf_rd_addr_a == 5'h00) ? 1'b0 : rf_tag[rf_rd_addr_a]);
    {next_state.rd_tag_b, next_state.rd_cap_b} =
      cbc_rf_read(rf_rd_addr_b,
                  (rf_rd_addr_b == 5'h00) ? '0 : rf_cap[rf_rd_addr_b],
                  (rf_rd_addr_b == 5'h00) ? 1'b0 : rf_tag[rf_rd_addr_b]);

    // Pointer arithmetic result
    next_state.ar_res_valid = ar_valid;
    if (ar_valid)
    begin
      next_state.ar_res_cap  = ar_new_cap;
      next_state.ar_res_repr = (old_base == new_base)
                               && (old_top == new_top); // see R10
      // No exception: the tag just drops
      next_state.ar_res_tag  = ar_tag
                               && next_state.ar_res_repr
                               && !arc.sealed
                               && !old_malformed;       // see R11, R14
    end

    // Memory response
    next_state.mem_rvalid     = mem_valid && !mem_we;
    next_state.mem_misaligned = mem_valid && !mem_word_ok;
    if (mem_valid && !mem_we)
    begin
      next_state.mem_rdata = mem_data[mem_idx];
      next_state.mem_rtag  = mem_tag[mem_idx] && mem_word_ok; // see R15
    end

    // Program counter capability
    next_state.pcc_fault = instr_valid && !pcc_ok;      // see R21
    if (pcc_load)
    begin
      next_state.pcc_cap = pcc_load_cap;
      next_state.pcc_tag = pcc_load_tag
                           && !cbc_pkg::cbc_malformed(cbc_pkg::cbc_cap_type'(pcc_load_cap)); // see R14
    end
    else if (instr_valid && pcc_ok)
    begin
      next_state.pcc_cap = {state.pcc_cap[`CBC_CW-1:`CBC_AW], pcc_next_addr};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state         <= '0;
      state.pcc_cap <= {`CBC_ROOT_META, `CBC_PCC_RESET_ADDR}; // see R20
      state.pcc_tag <= 1'b1;                            // see R20
    end
    else
    begin
      state <= next_state;
    end
  end

  // Constants: null is all zero, root only sets permissions
  assign null_cap = '0;                                 // see R08
  assign root_cap = {`CBC_ROOT_META, 32'h0000_0000};    // see R09

  // Registered outputs
  assign rf_rd_cap_a    = state.rd_cap_a;
  assign rf_rd_tag_a    = state.rd_tag_a;
  assign rf_rd_int_a    = cbc_addr_of(state.rd_cap_a);
  assign rf_rd_cap_b    = state.rd_cap_b;
  assign rf_rd_tag_b    = state.rd_tag_b;
  assign rf_rd_int_b    = cbc_addr_of(state.rd_cap_b);
  assign ar_res_valid   = state.ar_res_valid;
  assign ar_res_cap     = state.ar_res_cap;
  assign ar_res_tag     = state.ar_res_tag;
  assign ar_res_repr    = state.ar_res_repr;
  assign mem_rvalid     = state.mem_rvalid;
  assign mem_rdata      = state.mem_rdata;
  assign mem_rtag       = state.mem_rtag;
  assign mem_misaligned = state.mem_misaligned;
  assign pcc_cap        = state.pcc_cap;
  assign pcc_tag        = state.pcc_tag;
  assign pcc_fault      = state.pcc_fault;

endmodule : cbc_capability_unit

/* rtl/cbc_regs.svh */
/*
  Constants of the capability bounds checker: widths, field sizes,
  reset values and memory geometry. Assumes 32-bit addresses and
  64-bit capabilities; included by bare name.
*/
`ifndef CBC_REGS_SVH
`define CBC_REGS_SVH

`define CBC_AW             32
`define CBC_CW             64
`define CBC_MW             10 // see R22
`define CBC_EW             5 // see R23
`define CBC_MAX_E          24
`define CBC_SDP_W          2
`define CBC_AP_W           4
`define CBC_RSV_W          5
`define CBC_TF_W           8
`define CBC_EXP_HALF       2
`define CBC_PERM_X         3
`define CBC_NREG           32
`define CBC_RIDX_W         5
`define CBC_TMEM_AW        8
`define CBC_WORD_LSB       3
`define CBC_ROOT_META      32'hfc00_0000
`define CBC_PCC_RESET_ADDR 32'h0000_0000

`endif

/* rtl/cbc_pkg.sv */
/*
  Types and shared decode helpers of the capability bounds checker.
  Assumes the constants header is on the include path.
*/
`include "cbc_regs.svh"

package cbc_pkg;

  typedef struct packed
  {
    logic [`CBC_SDP_W-1:0] software_permission_bits;
    logic [`CBC_AP_W-1:0]  ap;
    logic                  sealed;
    logic [`CBC_RSV_W-1:0] rsv;
    logic                  exponent_format_flag;
    logic                  extra_top_bit;
    logic [`CBC_TF_W-1:0]  t;
    logic [`CBC_MW-1:0]    b;
    logic [`CBC_AW-1:0]    addr;
  } cbc_cap_type;

  typedef enum logic [1:0]
  {
    CBC_OP_SET = 2'b01,
    CBC_OP_INC = 2'b10
  } cbc_op_type;

  typedef struct packed
  {
    logic [`CBC_CW-1:0] pcc_cap;
    logic               pcc_tag;
    logic               pcc_fault;
    logic [`CBC_CW-1:0] rd_cap_a;
    logic               rd_tag_a;
    logic [`CBC_CW-1:0] rd_cap_b;
    logic               rd_tag_b;
    logic               ar_res_valid;
    logic [`CBC_CW-1:0] ar_res_cap;
    logic               ar_res_tag;
    logic               ar_res_repr;
    logic               mem_rvalid;
    logic [`CBC_CW-1:0] mem_rdata;
    logic               mem_rtag;
    logic               mem_misaligned;
  } cbc_state_type;

  // Bounds fields only; reserved bits deliberately ignored
  function automatic logic cbc_malformed(cbc_cap_type c);
    logic [`CBC_EW-1:0] enc;
    enc = {c.extra_top_bit, c.t[`CBC_EXP_HALF-1:0], c.b[`CBC_EXP_HALF-1:0]};
    return !c.exponent_format_flag &&
           ((enc == 5'h00 && c.b[`CBC_MW-1 -: 2] != 2'h0) ||
            (enc == 5'h01 && c.b[`CBC_MW-1]) ||
            (enc > 5'(`CBC_MAX_E)));
  endfunction : cbc_malformed

endpackage : cbc_pkg

/* rtl/cbc_bounds_decode.sv */
/*
  Combinational bounds decoder: base, top and malformed flag of one
  capability against a given address. Assumes cbc_pkg is compiled.
*/
`timescale 1ns/1ps
`include "cbc_regs.svh"

module cbc_bounds_decode (
  // Capability and address
  input  wire logic [`CBC_CW-1:0] cap,
  input  wire logic [`CBC_AW-1:0] addr,
  // Decoded bounds
  output logic      [`CBC_AW-1:0] base,
  output logic      [`CBC_AW:0]   top,
  output logic                    malformed
);

  cbc_pkg::cbc_cap_type c;
  logic signed [6:0]    e;
  logic [4:0]           sh;
  logic [`CBC_MW-1:0]   tf;
  logic [`CBC_MW-1:0]   bf;
  logic                 lcout;
  logic                 lmsb;
  logic [2:0]           ac;
  logic [2:0]           r;
  logic [39:0]          ab;
  logic [39:0]          hi;
  logic [39:0]          top_w;
  logic [39:0]          base_w;
  logic [2:0]           d;

  // Slice below the boundary lies one aligned region up
  function automatic logic [39:0] cbc_corr(logic a_lo, logic m_lo);
    if (a_lo == m_lo)
      return 40'h00_0000_0000;
    else if (m_lo)
      return 40'h00_0000_0001;
    else
      return 40'hff_ffff_ffff;
  endfunction : cbc_corr

  always_comb
  begin
    c         = cbc_pkg::cbc_cap_type'(cap);
    malformed = cbc_pkg::cbc_malformed(c);              // see R12, R13
    if (c.exponent_format_flag)
    begin
      e     = 7'sd0;                                    // see R01
      tf    = {2'h0, c.t};
      bf    = c.b;
      lcout = c.t < c.b[`CBC_TF_W-1:0];
      lmsb  = c.extra_top_bit;
    end
    else
    begin
      e     = 7'(`CBC_MAX_E) - {2'h0, c.extra_top_bit, c.t[1:0], c.b[1:0]}; // see R02
      tf    = {2'h0, c.t[`CBC_TF_W-1:`CBC_EXP_HALF], 2'h0};
      bf    = {c.b[`CBC_MW-1:`CBC_EXP_HALF], 2'h0};
      lcout = c.t[`CBC_TF_W-1:`CBC_EXP_HALF] < c.b[`CBC_TF_W-1:`CBC_EXP_HALF];
      lmsb  = 1'b1;
    end
    tf[`CBC_MW-1 -: 2] = bf[`CBC_MW-1 -: 2] + {1'b0, lcout} + {1'b0, lmsb}; // see R03
    // Negative exponent only on malformed input; clamp keeps shifts sane
    sh     = e[6] ? 5'h00 : e[4:0];
    ab     = {8'h00, addr};
    ac     = ab[{1'b0, sh} + 6'(`CBC_MW - 3) +: 3];
    r      = bf[`CBC_MW-1 -: 3] - 3'h1;                 // see R04
    hi     = ab >> ({1'b0, sh} + 6'(`CBC_MW));
    top_w  = ((hi + cbc_corr(ac < r, tf[`CBC_MW-1 -: 3] < r)) << ({1'b0, sh} + 6'(`CBC_MW)))
             | ({30'h0, tf} << sh);                     // see R24, R25, R05
    base_w = ((hi + cbc_corr(ac < r, bf[`CBC_MW-1 -: 3] < r)) << ({1'b0, sh} + 6'(`CBC_MW)))
             | ({30'h0, bf} << sh);                     // see R24, R25
    top    = top_w[`CBC_AW:0];                          // see R07
    base   = base_w[`CBC_AW-1:0];                       // see R17
    d      = {1'b0, top[`CBC_AW -: 2]} - {2'h0, base[`CBC_AW-1]};
    if ((e < $signed(7'(`CBC_MAX_E - 1))) && !d[2] && d[1])
      top[`CBC_AW] = !top[`CBC_AW];                     // see R06
  end

endmodule : cbc_bounds_decode

/* testbench/cbc_unit_asserts.sv */
/*
  Port checker of the capability unit.
  Assumes a bind to cbc_capability_unit and one core clock.
*/
`timescale 1ns/1ps

module cbc_unit_asserts
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Register file
  input wire logic [4:0]  rf_rd_addr_a,
  input wire logic [63:0] rf_rd_cap_a,
  input wire logic        rf_rd_tag_a,
  input wire logic [31:0] rf_rd_int_a,
  // Pointer arithmetic
  input wire logic        ar_valid,
  input wire logic        ar_res_valid,
  input wire logic        ar_res_tag,
  input wire logic        ar_res_repr,
  // Inspection and constants
  input wire logic [32:0] in_top,
  input wire logic        in_malformed,
  input wire logic [63:0] null_cap,
  input wire logic [63:0] root_cap,
  // Memory
  input wire logic        mem_valid,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_rvalid,
  input wire logic        mem_misaligned,
  // Program counter capability
  input wire logic        pcc_load,
  input wire logic        instr_valid,
  input wire logic [63:0] pcc_cap,
  input wire logic        pcc_tag,
  input wire logic        pcc_fault
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  null_const_a: assert property (null_cap == 64'h0)
    else $error("null constant not zero");
  root_const_a: assert property (root_cap == 64'hfc00_0000_0000_0000)
    else $error("root constant wrong");
  zero_reg_a: assert property (rf_rd_addr_a == 5'h0 |=> rf_rd_cap_a == 64'h0 && !rf_rd_tag_a)
    else $error("register zero not zero");
  int_view_a: assert property (rf_rd_int_a == rf_rd_cap_a[31:0])
    else $error("integer view differs from address");
  ar_pulse_a: assert property (ar_res_valid == $past(ar_valid))
    else $error("arithmetic result timing wrong");
  repr_tag_a: assert property (ar_res_valid && !ar_res_repr |-> !ar_res_tag)
    else $error("unrepresentable result kept tag");
  mem_align_a: assert property (mem_valid |=> mem_misaligned == ($past(mem_addr[2:0]) != 3'h0))
    else $error("misaligned flag wrong");
  mem_read_a: assert property (mem_valid && !mem_we |=> mem_rvalid)
    else $error("read answer missing");
  pcc_reset_a: assert property ($fell(rst) |-> pcc_cap == 64'hfc00_0000_0000_0000 && pcc_tag)
    else $error("pcc reset value wrong");
  pcc_hold_a: assert property (instr_valid && !pcc_load ##1 pcc_fault |-> $stable(pcc_cap))
    else $error("faulting instruction moved pcc");
  top_width_a: assert property (!in_malformed |-> in_top <= 33'h1_0000_0000)
    else $error("decoded top beyond address space");
endmodule : cbc_unit_asserts

bind cbc_capability_unit cbc_unit_asserts i_chk
(
  .clk_sys, .rst, .rf_rd_addr_a, .rf_rd_cap_a, .rf_rd_tag_a, .rf_rd_int_a,
  .ar_valid, .ar_res_valid, .ar_res_tag, .ar_res_repr, .in_top, .in_malformed, .null_cap, .root_cap,
  .mem_valid, .mem_we, .mem_addr, .mem_rvalid, .mem_misaligned,
  .pcc_load, .instr_valid, .pcc_cap, .pcc_tag, .pcc_fault
);

/* testbench/cbc_core_model.sv */
/*
  Core pipeline stand-in that retires one instruction on request.
  Assumes the bench raises go off the clock edge.
*/
`timescale 1ns/1ps

module cbc_core_model
(
  // Request from the bench
  input  wire logic        go,
  input  wire logic [2:0]  len,
  // Current pcc
  input  wire logic [63:0] pcc_cap,
  // Retire towards the unit
  output logic             instr_valid,
  output logic [2:0]       instr_len,
  output logic [31:0]      pcc_next_addr
);
  assign instr_valid   = go;
  assign instr_len     = len;
  // Sequential pc; wraps past the top of the space
  assign pcc_next_addr = pcc_cap[31:0] + 32'(len);
endmodule : cbc_core_model

/* testbench/tb.sv */
/*
  Self-checking bench of the capability unit.
  Assumes the package, header, checker and core model are compiled.
*/
`timescale 1ns/1ps

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module tb;
  localparam logic [63:0] ROOT = 64'hfc00_0000_0000_0000;
  localparam logic [63:0] EMB  = 64'hfc08_8010_1000_0015;
  localparam logic [63:0] MALF = 64'hfc00_0100_0000_0000;
  localparam logic [63:0] D    = 64'h0123_4567_89ab_cdef;
  logic        clk_sys = 0, rst = 1, go = 0, rf_wr_en = 0, rf_wr_int = 0, rf_wr_tag = 0;
  logic        ar_valid = 0, ar_tag = 0, mem_valid = 0, mem_we = 0, mem_wtag = 0, pcc_load = 0, pcc_load_tag = 0;
  logic [4:0]  rf_rd_addr_a = 0, rf_rd_addr_b = 0, rf_wr_addr = 0;
  logic [63:0] rf_wr_cap = 0, ar_cap = 0, in_cap = 0, mem_wdata = 0, pcc_load_cap = 0;
  logic [31:0] ar_operand = 0, mem_addr = 0, rf_rd_int_a, rf_rd_int_b, in_base, pcc_next_addr;
  logic [2:0]  len = 0, instr_len;
  logic [32:0] in_top;
  logic [63:0] rf_rd_cap_a, rf_rd_cap_b, ar_res_cap, null_cap, root_cap, mem_rdata, pcc_cap;
  logic        rf_rd_tag_a, rf_rd_tag_b, ar_res_valid, ar_res_tag, ar_res_repr, in_malformed;
  logic        mem_rvalid, mem_rtag, mem_misaligned, pcc_tag, pcc_fault, instr_valid;
  cbc_pkg::cbc_op_type ar_op = cbc_pkg::CBC_OP_SET;
  int          failures = 0, total_checks = 0;
  logic [63:0] mcap [7] = '{64'h0, 64'h01f0_0000_0000_0000, 64'h0000_0100_0000_0000, 64'h0008_0100_0000_0000,
                            64'h0000_0201_0000_0000, 64'h0000_0001_0000_0000, 64'h0004_0c03_0000_0000};
  logic        mexp [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [63:0] fcap [4] = '{64'hfe00_0000_0000_0000, 64'hdc00_0000_0000_0000, ROOT, MALF};
  logic        ftag [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic        fexp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  cbc_capability_unit i_dut
  (
    .clk_sys, .rst, .rf_rd_addr_a, .rf_rd_addr_b, .rf_rd_cap_a, .rf_rd_tag_a, .rf_rd_int_a,
    .rf_rd_cap_b, .rf_rd_tag_b, .rf_rd_int_b, .rf_wr_en, .rf_wr_int, .rf_wr_addr, .rf_wr_cap, .rf_wr_tag,
    .ar_valid, .ar_op, .ar_cap, .ar_tag, .ar_operand, .ar_res_valid, .ar_res_cap, .ar_res_tag, .ar_res_repr,
    .in_cap, .in_base, .in_top, .in_malformed, .null_cap, .root_cap, .mem_valid, .mem_we, .mem_addr,
    .mem_wdata, .mem_wtag, .mem_rvalid, .mem_rdata, .mem_rtag, .mem_misaligned, .pcc_load, .pcc_load_cap,
    .pcc_load_tag, .instr_valid, .instr_len, .pcc_next_addr, .pcc_cap, .pcc_tag, .pcc_fault
  );

  cbc_core_model i_core
  (
    .go, .len, .pcc_cap, .instr_valid, .instr_len, .pcc_next_addr
  );

  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Strobe left high so writes can run back to back
  task automatic rf_wr(input logic [4:0] a, input logic [63:0] c, input logic t, input logic i);
    rf_wr_en = 1;
    rf_wr_addr = a;
    rf_wr_cap = c;
    rf_wr_tag = t;
    rf_wr_int = i;
    @(negedge clk_sys);
  endtask : rf_wr

  task automatic rf_rd(input logic [4:0] a, input logic [63:0] c, input logic t);
    rf_wr_en = 0;
    rf_rd_addr_a = a;
    rf_rd_addr_b = a;
    @(negedge clk_sys);
    `CHK(rf_rd_cap_a, c)
    `CHK(rf_rd_cap_b, c)
    `CHK(rf_rd_tag_a, t)
    `CHK(rf_rd_tag_b, t)
    `CHK(rf_rd_int_b, c[31:0])
  endtask : rf_rd

  task automatic ar(input cbc_pkg::cbc_op_type op, input logic [63:0] c, input logic t, input logic [31:0] x,
                    input logic [31:0] na, input logic et, input logic er);
    ar_valid = 1;
    ar_op = op;
    ar_cap = c;
    ar_tag = t;
    ar_operand = x;
    @(negedge clk_sys);
    `CHK(ar_res_valid, 1'b1)
    `CHK(ar_res_cap, {c[63:32], na})
    `CHK(ar_res_tag, et)
    `CHK(ar_res_repr, er)
  endtask : ar

  task automatic mem(input logic w, input logic [31:0] a, input logic [63:0] d, input logic t,
                     input logic m, input logic et);
    mem_valid = 1;
    mem_we = w;
    mem_addr = a;
    mem_wdata = d;
    mem_wtag = t;
    @(negedge clk_sys);
    `CHK(mem_misaligned, m)
    `CHK(mem_rvalid, !w)
    if (!w)
    begin
      `CHK(mem_rdata, D)
      `CHK(mem_rtag, et)
    end
  endtask : mem

  task automatic pcc_ld(input logic [63:0] c, input logic t, input logic et);
    go = 0;
    pcc_load = 1;
    pcc_load_cap = c;
    pcc_load_tag = t;
    @(negedge clk_sys);
    pcc_load = 0;
    `CHK(pcc_cap, c)
    `CHK(pcc_tag, et)
  endtask : pcc_ld

  task automatic instr(input logic [2:0] l, input logic f, input logic [31:0] ea);
    go = 1;
    len = l;
    @(negedge clk_sys);
    `CHK(pcc_fault, f)
    `CHK(pcc_cap[31:0], ea)
  endtask : instr

  task automatic insp(input logic [63:0] c, input logic [31:0] eb, input logic [32:0] et);
    in_cap = c;
    #1;
    `CHK(in_base, eb)
    `CHK(in_top, et)
    `CHK(in_malformed, 1'b0)
    @(negedge clk_sys);
  endtask : insp

  initial
  begin
    #100000;
    failures++;
    end_of_test;
  end

  initial
  begin
    repeat (6) @(negedge clk_sys);
    rst = 0;
    @(negedge clk_sys);
    `CHK(pcc_cap, ROOT)
    `CHK(pcc_tag, 1'b1)
    `CHK(null_cap, 64'h0)
    `CHK(root_cap, ROOT)
    $display("Test reset done");
    insp(64'h0, 32'h0, 33'h1_0000_0000);
    insp(ROOT, 32'h0, 33'h1_0000_0000);
    insp(EMB, 32'h1000_0010, 33'h0_1000_0020);
    foreach (mcap[i])
    begin
      in_cap = mcap[i];
      #1;
      `CHK(in_malformed, mexp[i])
      @(negedge clk_sys);
    end
    $display("Test bounds done");
    rf_wr(5'h5, ROOT, 1'b1, 1'b0);
    rf_wr(5'h0, ROOT, 1'b1, 1'b0);
    rf_wr(5'h6, ROOT | 64'h1234, 1'b1, 1'b1);
    rf_wr(5'h7, MALF, 1'b1, 1'b0);
    rf_rd(5'h5, ROOT, 1'b1);
    rf_rd(5'h0, 64'h0, 1'b0);
    rf_rd(5'h6, 64'h1234, 1'b0);
    rf_rd(5'h7, MALF, 1'b0);
    $display("Test registers done");
    ar(cbc_pkg::CBC_OP_INC, EMB, 1'b1, 32'h10, 32'h1000_0025, 1'b1, 1'b1);
    ar(cbc_pkg::CBC_OP_INC, EMB, 1'b1, 32'h3eb, 32'h1000_0400, 1'b0, 1'b0);
    ar(cbc_pkg::CBC_OP_SET, EMB, 1'b1, 32'h1000_0300, 32'h1000_0300, 1'b1, 1'b1);
    ar(cbc_pkg::CBC_OP_SET, EMB, 1'b1, 32'h0fff_ff90, 32'h0fff_ff90, 1'b1, 1'b1);
    ar(cbc_pkg::CBC_OP_SET, EMB, 1'b1, 32'h2000_0000, 32'h2000_0000, 1'b0, 1'b0);
    ar(cbc_pkg::CBC_OP_INC, EMB, 1'b0, 32'h10, 32'h1000_0025, 1'b0, 1'b1);
    ar(cbc_pkg::CBC_OP_INC, 64'hfe08_8010_1000_0015, 1'b1, 32'h10, 32'h1000_0025, 1'b0, 1'b1);
    ar_valid = 0;
    @(negedge clk_sys);
    `CHK(ar_res_valid, 1'b0)
    $display("Test arithmetic done");
    mem(1'b1, 32'h0000_0008, D, 1'b1, 1'b0, 1'b0);
    mem(1'b0, 32'h0000_0808, 64'h0, 1'b0, 1'b0, 1'b1);
    mem(1'b1, 32'h0000_0009, ~D, 1'b0, 1'b1, 1'b0);
    mem(1'b0, 32'h0000_000b, 64'h0, 1'b0, 1'b1, 1'b0);
    mem(1'b0, 32'h0000_0008, 64'h0, 1'b0, 1'b0, 1'b1);
    mem_valid = 0;
    $display("Test memory done");
    instr(3'h4, 1'b0, 32'h4);
    pcc_ld(ROOT | 64'hffff_fffc, 1'b1, 1'b1);
    instr(3'h4, 1'b0, 32'h0);
    foreach (fcap[i])
    begin
      pcc_ld(fcap[i], ftag[i], fexp[i]);
      instr(3'h4, 1'b1, 32'h0);
    end
    pcc_ld(EMB + 64'h9, 1'b1, 1'b1);
    instr(3'h2, 1'b0, 32'h1000_0020);
    instr(3'h4, 1'b1, 32'h1000_0020);
    $display("Test pcc done");
    end_of_test;
  end
endmodule : tb
